/* include/adcc_defs.svh */
// Holds the address, field and timing constants of the converter control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define ADCC_IDX_CTRL 12'h0F70
`define ADCC_IDX_UPPER 12'h0F72
`define ADCC_IDX_LOWER 12'h0F73
`define ADCC_ADR_MSB 13
`define ADCC_ADR_LSB 2
// ****************************************************************
// Control register fields.
// ****************************************************************
`define ADCC_GO_BIT 7
`define ADCC_VREF_BIT 5
`define ADCC_REP_BIT 4
`define ADCC_CHAN_MSB 3
`define ADCC_CHAN_LIMIT 4'hC
// ****************************************************************
// Timing figures in system clock cycles.
// ****************************************************************
`define ADCC_CONV_TIME 16'h1409
`define ADCC_REP_TIME 16'h0100
`define ADCC_IDLE_TIME 16'h00A0
`define ADCC_PWRUP_TIME 16'h0028
`define ADCC_CONV_CYC (13'(`ADCC_CONV_TIME))
`define ADCC_REP_CYC (13'(`ADCC_REP_TIME))
`define ADCC_IDLE_CYC (8'(`ADCC_IDLE_TIME))
`define ADCC_PWRUP_CYC (13'(`ADCC_PWRUP_TIME))
`endif

/* include/adcc_pkg.sv */
// Holds the types shared by the converter control block and its bench.
// Assumes the constant header is on the include path.
`include "adcc_defs.svh"
package adcc_pkg;
    // Sequencer phases.
    typedef enum logic [1:0] {ADCC_IDLE, ADCC_PWRUP, ADCC_CONV, ADCC_REPEAT} adcc_phase_t;
    // Classic Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } adcc_wb_req_t;
    // Steering toward the converter core and input multiplexer.
    typedef struct packed {
        logic power;
        logic run;
        logic sample_take;
        logic vref_int_en;
        logic chan_valid;
        logic [3:0] chan;
    } adcc_core_t;
    // Whole state of the control block.
    typedef struct packed {
        adcc_phase_t fsm;
        logic go;
        logic vref;
        logic rep;
        logic [3:0] chan;
        logic powered;
        logic [12:0] cnt;
        logic [7:0] idle;
        logic [9:0] result;
        logic [1:0] low;
        logic ack;
        logic [31:0] dat;
    } adcc_state_t;
endpackage : adcc_pkg

/* design/adcc_ctrl.sv */
// Holds the register front end and sequencer of the converter control block.
// Assumes a classic Wishbone master and a converter core that presents its
// current sample on core_data_i whenever sample_take is high.
//
// Contract
// - Writing go one starts a conversion.
// - Go during conversion restarts it from start.
// - Go stays one until conversion finishes.
// - Writing go zero does nothing.
// - Reference bit zero enables internal reference.
// - Single shot outputs once after 5129 cycles.
// - Repeat mode updates result every 256 cycles.
// - Channel codes 0 to 11; 11xx reserved.
// - Result upper byte, low bits 7:6.
// - Upper byte invalid during single shot.
// - Repeat mode holds latest completed result.
// - Upper read latches matching low bits.
// - Result registers ignore writes.
// - Low register bits 5:0 reserved.
// - Result registers undefined after reset; this block clears them to zero.
// - Completion request on every conversion.
// - Power down after 160 idle; 40 up.
// - Repeat mode clears go after first.
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire adcc_pkg::adcc_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [9:0] core_data_i,
    output adcc_pkg::adcc_core_t core_o,
    output logic irq_o
);
    import adcc_pkg::*;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************

    // Tells whether a bus address selects the register at an index.
    function automatic logic reg_hit(input logic [31:0] adr, input logic [11:0] idx);
        reg_hit = (adr[`ADCC_ADR_MSB:`ADCC_ADR_LSB] == idx);
    endfunction : reg_hit

    adcc_state_t st_reg;
    adcc_state_t st_next;
    logic acc;
    logic wr_ctrl;
    logic go_wr;
    logic rd;
    logic done;
    logic phase_start;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Bus decode, sequencer and register effects in one pass.
    always_comb begin
        st_next = st_reg;
        acc = wb_req_i.cyc && wb_req_i.stb && !st_reg.ack;
        rd = acc && !wb_req_i.we;
        // Result registers have no write path at all.
        wr_ctrl = acc && wb_req_i.we && wb_req_i.sel[0]
                  && reg_hit(wb_req_i.adr, `ADCC_IDX_CTRL);
        // A zero in the go bit is simply not acted on.
        go_wr = wr_ctrl && wb_req_i.dat[`ADCC_GO_BIT];
        done = ((st_reg.fsm == ADCC_CONV) || (st_reg.fsm == ADCC_REPEAT))
               && (st_reg.cnt == '0);
        st_next.ack = acc;
        case (st_reg.fsm)
            ADCC_IDLE: begin
                // Idle cycles are counted while powered.
                if (st_reg.powered) begin
                    if (st_reg.idle == `ADCC_IDLE_CYC - 8'(1)) begin
                        st_next.powered = 1'b0;
                    end else begin
                        st_next.idle = st_reg.idle + 8'(1);
                    end
                end
            end
            ADCC_PWRUP: begin
                // Power-up delay precedes the conversion.
                if (st_reg.cnt == '0) begin
                    st_next.fsm = ADCC_CONV;
                    st_next.powered = 1'b1;
                    st_next.cnt = `ADCC_CONV_CYC - 13'(1);
                end else begin
                    st_next.cnt = st_reg.cnt - 13'(1);
                end
            end
            ADCC_CONV: begin
                if (done) begin
                    // Sample taken in the completing cycle.
                    st_next.result = core_data_i;
                    // Hardware clears go at completion.
                    st_next.go = 1'b0;
                    if (st_reg.rep) begin
                        st_next.fsm = ADCC_REPEAT;
                        st_next.cnt = `ADCC_REP_CYC - 13'(1);
                    end else begin
                        st_next.fsm = ADCC_IDLE;
                        st_next.idle = '0;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt - 13'(1);
                end
            end
            ADCC_REPEAT: begin
                if (done) begin
                    // Each new sample overwrites the held one.
                    st_next.result = core_data_i;
                    st_next.cnt = `ADCC_REP_CYC - 13'(1);
                end else begin
                    st_next.cnt = st_reg.cnt - 13'(1);
                end
                // Leaving repeat mode still keeps a sample that lands now, so no
                // completion pulse goes out without its result.
                if (!st_reg.rep) begin
                    st_next.fsm = ADCC_IDLE;
                    st_next.idle = '0;
                end
            end
            default: begin
                st_next.fsm = ADCC_IDLE;
            end
        endcase
        // Control register write; a restart overrides completion.
        if (wr_ctrl) begin
            st_next.vref = wb_req_i.dat[`ADCC_VREF_BIT];
            st_next.rep = wb_req_i.dat[`ADCC_REP_BIT];
            st_next.chan = wb_req_i.dat[`ADCC_CHAN_MSB:0];
        end
        if (go_wr) begin
            st_next.go = 1'b1;
            if (st_reg.powered) begin
                st_next.fsm = ADCC_CONV;
                st_next.cnt = `ADCC_CONV_CYC - 13'(1);
            end else begin
                st_next.fsm = ADCC_PWRUP;
                st_next.cnt = `ADCC_PWRUP_CYC - 13'(1);
            end
        end
        // Read data; reserved bits read as zero.
        if (acc) begin
            st_next.dat = '0;
        end
        if (rd && reg_hit(wb_req_i.adr, `ADCC_IDX_CTRL)) begin
            st_next.dat[7:0] = {st_reg.go, 1'b0, st_reg.vref, st_reg.rep, st_reg.chan};
        end
        if (rd && reg_hit(wb_req_i.adr, `ADCC_IDX_UPPER)) begin
            st_next.dat[7:0] = st_reg.result[9:2];
            st_next.low = st_reg.result[1:0];
        end
        if (rd && reg_hit(wb_req_i.adr, `ADCC_IDX_LOWER)) begin
            st_next.dat[7:0] = {st_reg.low, 6'h00};
        end
        phase_start = (st_next.fsm != st_reg.fsm) || go_wr || done;
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Synchronous reset clears everything, results included.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Bus answer and core steering.
    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.dat;
    assign core_o.power = st_reg.powered || (st_reg.fsm == ADCC_PWRUP);
    assign core_o.run = (st_reg.fsm == ADCC_CONV) || (st_reg.fsm == ADCC_REPEAT);
    assign core_o.sample_take = done;
    assign core_o.vref_int_en = !st_reg.vref;
    assign core_o.chan_valid = (st_reg.chan < `ADCC_CHAN_LIMIT);
    assign core_o.chan = st_reg.chan;
    assign irq_o = done;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Counts cycles since the current phase or sample period began.
    logic [12:0] hlp_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || phase_start) begin
            hlp_reg <= '0;
        end else begin
            hlp_reg <= hlp_reg + 13'(1);
        end
    end

    property p_go_start;
        go_wr |=> st_reg.go && (core_o.power) && (st_reg.fsm != ADCC_IDLE);
    endproperty
    a_go_start: assert property (p_go_start) else $error("go write did not start");

    property p_restart;
        go_wr && core_o.run |=> (st_reg.fsm == ADCC_CONV)
            && (st_reg.cnt == `ADCC_CONV_CYC - 13'(1));
    endproperty
    a_restart: assert property (p_restart) else $error("running go write did not restart");

    property p_go_busy;
        st_reg.go |-> (st_reg.fsm == ADCC_PWRUP) || (st_reg.fsm == ADCC_CONV);
    endproperty
    a_go_busy: assert property (p_go_busy) else $error("go bit high while not converting");

    property p_zero_write;
        wr_ctrl && !go_wr && (st_reg.fsm == ADCC_CONV) && !done
            |=> (st_reg.fsm == ADCC_CONV) && $stable(st_reg.go);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("go zero disturbed conversion");

    property p_vref;
        core_o.vref_int_en != st_reg.vref;
    endproperty
    a_vref: assert property (p_vref) else $error("reference enable wrong");

    property p_single_time;
        done && (st_reg.fsm == ADCC_CONV) |-> hlp_reg == `ADCC_CONV_CYC - 13'(1);
    endproperty
    a_single_time: assert property (p_single_time) else $error("conversion length wrong");

    property p_repeat_time;
        done && (st_reg.fsm == ADCC_REPEAT) |-> hlp_reg == `ADCC_REP_CYC - 13'(1);
    endproperty
    a_repeat_time: assert property (p_repeat_time) else $error("repeat period wrong");

    property p_low_latch;
        rd && reg_hit(wb_req_i.adr, `ADCC_IDX_UPPER)
            |=> (st_reg.low == $past(st_reg.result[1:0])) && wb_ack_o;
    endproperty
    a_low_latch: assert property (p_low_latch) else $error("low bits not latched");

    property p_ro_result;
        !done |=> $stable(st_reg.result);
    endproperty
    a_ro_result: assert property (p_ro_result) else $error("result changed without sample");

    property p_irq_result;
        irq_o |=> st_reg.result == $past(core_data_i);
    endproperty
    a_irq_result: assert property (p_irq_result) else $error("irq without result");

    property p_pwrup_time;
        (st_reg.fsm == ADCC_PWRUP) && (st_next.fsm == ADCC_CONV) && !go_wr
            |-> hlp_reg == `ADCC_PWRUP_CYC - 13'(1);
    endproperty
    a_pwrup_time: assert property (p_pwrup_time) else $error("power-up length wrong");

    property p_rep_go;
        done && st_reg.rep && !go_wr |=> (!st_reg.go) [*2];
    endproperty
    a_rep_go: assert property (p_rep_go) else $error("go set in repeat mode");

    property p_upper_data;
        rd && reg_hit(wb_req_i.adr, `ADCC_IDX_UPPER) |=> wb_dat_o[7:0] == $past(st_reg.result[9:2]);
    endproperty
    a_upper_data: assert property (p_upper_data) else $error("upper byte read wrong");

    property p_lower_data;
        rd && reg_hit(wb_req_i.adr, `ADCC_IDX_LOWER)
            |=> (wb_dat_o[7:6] == $past(st_reg.low)) && (wb_dat_o[5:0] == 6'h00);
    endproperty
    a_lower_data: assert property (p_lower_data) else $error("lower bits read wrong");

    property p_chan_reserved;
        (st_reg.chan[3:2] == 2'h3) |-> !core_o.chan_valid;
    endproperty
    a_chan_reserved: assert property (p_chan_reserved) else $error("reserved channel valid");

    property p_irq_pulse;
        irq_o |=> !irq_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("completion pulse too long");

    property p_pdown_time;
        $fell(st_reg.powered) |-> $past(st_reg.idle) == `ADCC_IDLE_CYC - 8'(1);
    endproperty
    a_pdown_time: assert property (p_pdown_time) else $error("power-down too early");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("bus acknowledge too long");

    c_single: cover property (done && !st_reg.rep);
    c_repeat: cover property (done && (st_reg.fsm == ADCC_REPEAT));
    c_restart: cover property (go_wr && core_o.run);
    c_pdown: cover property ($fell(st_reg.powered));

endmodule : adcc_ctrl

/* verif/adcc_core_model.sv */
// Holds a behavioural model of the converter core and the input multiplexer.
// Assumes it sees the steering outputs of the control block on the same clock.
`timescale 1ns/1ps
module adcc_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire adcc_pkg::adcc_core_t core_i,
    output logic [9:0] data_o,
    output logic [5:0] taken_o
);
    import adcc_pkg::*;
    logic [9:0] junk_reg;
    // ****************************************************************
    // Sample source.
    // ****************************************************************
    // A sample is the channel code over a running count, so a stale sample shows.
    assign data_o = (core_i.power && core_i.run) ? {core_i.chan, taken_o} : junk_reg;
    // Counts samples taken; outside a run the lines toggle every cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            taken_o <= 6'h00;
            junk_reg <= 10'h155;
        end else begin
            junk_reg <= ~junk_reg;
            if (core_i.sample_take) begin
                taken_o <= taken_o + 6'h01;
            end
        end
    end
endmodule : adcc_core_model

/* verif/testbench.sv */
// Holds the self-checking bench of the converter control block.
// Assumes the package, the constant header and the core model compile first.
`timescale 1ns/1ps
`include "adcc_defs.svh"
module testbench;
    import adcc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    adcc_wb_req_t req = '0;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [9:0] core_data;
    adcc_core_t core;
    logic irq_o;
    logic [5:0] taken;
    logic [31:0] rd;
    logic [9:0] expv;
    int err_total = 0;
    int tests_run = 0;
    // ****************************************************************
    // Clock, design and core model.
    // ****************************************************************
    // Free-running system clock.
    always #12.5 clk_i = ~clk_i;
    adcc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .core_data_i(core_data), .core_o(core), .irq_o(irq_o));
    adcc_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .core_i(core), .data_o(core_data),
        .taken_o(taken));
    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    // Compares one value with its expectation and counts the outcome.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One classic bus cycle; read data is taken at the acknowledge edge.
    task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {18'h0_0000, idx, 2'h0}, sel: 4'h1,
            dat: {24'h00_0000, wd}};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        rd = wb_dat_o;
        req <= '0;
        chk("bus acknowledge", 32'h0000_0001, {31'h0, wb_ack_o});
    endtask : wb
    // Counts edges from now until the completion pulse is seen.
    task automatic wirq(input int exp);
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (irq_o !== 1'b1 && k < 6000);
        chk("completion delay", exp, k);
    endtask : wirq
    // Reads both result registers and checks them against the last sample.
    task automatic rd_result(input logic [3:0] c);
        wb(1'b0, `ADCC_IDX_UPPER, 8'h00);
        expv = {c, taken - 6'h01};
        chk("result upper", {24'h00_0000, expv[9:2]}, rd);
        wb(1'b0, `ADCC_IDX_LOWER, 8'h00);
        chk("result lower", {30'h0, expv[1:0]}, {30'h0, rd[7:6]});
    endtask : rd_result
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    // Reset values, an unmapped place and writes to read-only results.
    task automatic t_regs();
        logic [31:0] r0;
        wb(1'b0, `ADCC_IDX_CTRL, 8'h00);
        chk("control after reset", 32'h0000_0000, rd);
        wb(1'b0, 12'h0F71, 8'h00);
        chk("unmapped read", 32'h0000_0000, rd);
        wb(1'b0, `ADCC_IDX_UPPER, 8'h00);
        r0 = rd;
        wb(1'b1, `ADCC_IDX_UPPER, 8'hFF);
        wb(1'b1, `ADCC_IDX_LOWER, 8'hFF);
        wb(1'b0, `ADCC_IDX_UPPER, 8'h00);
        chk("upper after write", r0, rd);
    endtask : t_regs
    // Single shot from power-down with the external reference.
    task automatic t_single();
        wb(1'b1, `ADCC_IDX_CTRL, 8'hA5);
        @(negedge clk_i);
        chk("internal reference off", 32'h0, {31'h0, core.vref_int_en});
        chk("core powering", 32'h1, {31'h0, core.power});
        wirq(5168);
        wb(1'b0, `ADCC_IDX_CTRL, 8'h00);
        chk("go cleared", 32'h0000_0025, rd);
        rd_result(4'h5);
    endtask : t_single
    // Zero write ignored, then a restart in mid-run.
    task automatic t_restart();
        wb(1'b1, `ADCC_IDX_CTRL, 8'h83);
        chk("internal reference on", 32'h1, {31'h0, core.vref_int_en});
        chk("core running", 32'h1, {31'h0, core.run});
        wb(1'b0, `ADCC_IDX_CTRL, 8'h00);
        chk("go held", 32'h0000_0083, rd);
        wb(1'b1, `ADCC_IDX_CTRL, 8'h03);
        wb(1'b0, `ADCC_IDX_CTRL, 8'h00);
        chk("go after zero write", 32'h0000_0083, rd);
        wb(1'b1, `ADCC_IDX_CTRL, 8'h83);
        wirq(5128);
        rd_result(4'h3);
    endtask : t_restart
    // Continuous mode: cadence, go cleared, held result and low-bit latch.
    task automatic t_repeat();
        wb(1'b1, `ADCC_IDX_CTRL, 8'h97);
        wirq(5128);
        wirq(256);
        wb(1'b0, `ADCC_IDX_CTRL, 8'h00);
        chk("go in repeat", 32'h0000_0017, rd);
        wb(1'b0, `ADCC_IDX_UPPER, 8'h00);
        expv = {4'h7, taken - 6'h01};
        chk("held upper", {24'h00_0000, expv[9:2]}, rd);
        repeat (260) @(posedge clk_i);
        wb(1'b0, `ADCC_IDX_LOWER, 8'h00);
        chk("latched lower", {30'h0, expv[1:0]}, {30'h0, rd[7:6]});
        rd_result(4'h7);
        wb(1'b1, `ADCC_IDX_CTRL, 8'h07);
    endtask : t_repeat
    // Idle power-down.
    task automatic t_idle();
        repeat (150) @(posedge clk_i);
        chk("powered while idle", 32'h1, {31'h0, core.power});
        repeat (20) @(posedge clk_i);
        chk("powered down", 32'h0, {31'h0, core.power});
    endtask : t_idle
    // Every channel code, reserved ones included.
    task automatic t_chan();
        for (int c = 0; c < 16; c++) begin
            wb(1'b1, `ADCC_IDX_CTRL, {4'h0, 4'(c)});
            @(negedge clk_i);
            chk("channel", 32'(c), {28'h0, core.chan});
            chk("channel valid", 32'(c < 12), {31'h0, core.chan_valid});
        end
    endtask : t_chan
    // ****************************************************************
    // Main sequence and watchdog.
    // ****************************************************************
    // Resets the block, then runs every scenario in turn.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_single();
        t_restart();
        t_repeat();
        t_idle();
        t_chan();
        test_done();
    end
    // Cuts a hang short well beyond the longest expected run.
    initial begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        test_done();
    end
endmodule : testbench
